//--- design/tal_alarm_top.sv
// Thermal alarm output logic with two-wire slave and local register port.
//
// Contract
// R1 - Comparator style: above trip drives alarm active.
// R2 - Comparator: stays active until below hysteresis.
// R3 - Interrupt style: above trip sets, reads clear.
// R4 - Interrupt: drop below hysteresis sets again.
// R5 - Interrupt: only register reads and shutdown entry clear alarm.
// R6 - Interrupt: shutdown entry releases alarm at once.
// R7 - Comparator: alarm level frozen during shutdown.
// R8 - Host sets polarity, default active low.
// R9 - Alarm pin only pulls low or releases.
// R10 - Respond only when upper address is 1001.
// R11 - Acknowledge only when low bits match pins.
// R12 - Shutdown halts temperature conversions.
// R13 - Bus and registers work during shutdown.
// R14 - Programmable filter suppresses transient excursions.
// R15 - Queue 00/01/10/11 needs 1/2/4/6 conversions.
// R16 - Style bit 0 comparator, 1 interrupt.
// R17 - Polarity bit 0 low, 1 high.
// R18 - Shutdown bit 0 normal, 1 shutdown.
// R19 - Between limits comparator holds previous level.
// R20 - Compare results with same signed encoding.
//
// The register addresses and the plain strobed port were left to the implementer.
module tal_alarm_top #(
   parameter int unsigned CONV_CYCLES = tal_pkg::CONV_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic [1:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        addr_select_hi,
   input  wire logic        addr_select_mid,
   input  wire logic        addr_select_lo,
   input  wire logic [8:0]  temp_in,
   output logic             conv_active,
   output logic             alarm_out,
   output logic             alarm_oe
);
   import tal_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK, ST_WDATA, ST_RDATA, ST_RACK
   } tal_st_t;

   // Register file.
   logic [7:0]  cfg_r;
   logic [15:0] trip_r;
   logic [15:0] hyst_r;
   logic [15:0] temp_r;

   // Synchronised pins.
   logic [4:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic [2:0] addr_pins;
   logic       scl_q_r;
   logic       sda_q_r;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;

   // Serial slave state.
   tal_st_t    st_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] sh_r;
   logic [7:0] tx_r;
   logic [7:0] tx_byte;
   logic [15:0] tx_word;
   logic [7:0] msb_r;
   logic [1:0] ptr_r;
   logic [1:0] byte_idx_r;
   logic       rnw_r;
   logic       rd_half_r;
   logic       nack_r;
   logic       sda_oe_r;
   logic       i2c_wr_r;
   logic [15:0] i2c_wdata_r;
   logic       i2c_rd_r;

   // Conversion and alarm state.
   logic [CONV_CNT_W-1:0] conv_cnt_r;
   logic       conv_done_r;
   logic       conv_active_r;
   tal_cls_t   cls;
   logic       qual_hi;
   logic       qual_lo;
   logic       cmp_level_r;
   logic       int_pend_r;
   logic       int_expect_lo_r;
   logic       shdn_q_r;
   logic       shdn_entry;
   logic       any_read;
   logic       alarm_level;
   logic       alarm_oe_r;
   logic [15:0] rdata_r;

   // Register contents as seen by a reader; configuration bits above the writable mask read as zero.
   function automatic logic [15:0] reg_value(input logic [1:0] idx,
                                             input logic [7:0] cfg,
                                             input logic [15:0] tr,
                                             input logic [15:0] hy,
                                             input logic [15:0] tp);
      case (idx)
         REG_TEMP:   reg_value = tp;
         REG_CONFIG: reg_value = {8'h00, cfg & CFG_WR_MASK};
         REG_HYST:   reg_value = hy;
         default:    reg_value = tr;
      endcase
   endfunction

   // Signed temperature field of a register word.
   function automatic logic signed [8:0] temp_of(input logic [15:0] w);
      temp_of = $signed(w[15:TEMP_LSB]);
   endfunction

   // Pins cross into the clock domain; bus lines reset high so no false edge follows reset.
   tal_sync #(.W(5), .RST(5'h18)) u_sync (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .d       ({scl_in, sda_in, addr_select_hi, addr_select_mid, addr_select_lo}),
      .q       (pins_s)
   );

   assign scl_s     = pins_s[4];
   assign sda_s     = pins_s[3];
   assign addr_pins = pins_s[2:0];

   // Previous line levels for edge and condition detection.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end

   // A data change while the clock is high marks start or stop.
   assign scl_rise  = scl_s & ~scl_q_r;
   assign scl_fall  = ~scl_s & scl_q_r;
   assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
   assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;

   // Byte presented to the master; configuration repeats its one byte.
   always_comb begin
      tx_word = reg_value(ptr_r, cfg_r, trip_r, hyst_r, temp_r);
      tx_byte = (rd_half_r || ptr_r == REG_CONFIG) ? tx_word[7:0] : tx_word[15:8];
   end

   // R13 serial slave keeps running in shutdown.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r        <= ST_IDLE;
         bit_cnt_r   <= 4'h0;
         sh_r        <= 8'h00;
         tx_r        <= 8'h00;
         msb_r       <= 8'h00;
         ptr_r       <= REG_TEMP;
         byte_idx_r  <= 2'h0;
         rnw_r       <= 1'b0;
         rd_half_r   <= 1'b0;
         nack_r      <= 1'b0;
         sda_oe_r    <= 1'b0;
         i2c_wr_r    <= 1'b0;
         i2c_wdata_r <= 16'h0000;
         i2c_rd_r    <= 1'b0;
      end else begin
         i2c_wr_r <= 1'b0;
         i2c_rd_r <= 1'b0;
         if (start_det) begin
            st_r      <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b0;
         end else if (stop_det) begin
            st_r     <= ST_IDLE;
            sda_oe_r <= 1'b0;
         end else if (scl_rise) begin
            case (st_r)
               ST_ADDR, ST_WDATA: begin
                  sh_r      <= {sh_r[6:0], sda_s};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
               ST_RACK: begin
                  nack_r <= sda_s;
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            case (st_r)
               ST_ADDR: begin
                  if (bit_cnt_r == 4'h8) begin
                     // R10 fixed upper address.
                     // R11 strap match.
                     if (sh_r[7:4] == ADDR_FIXED && sh_r[3:1] == addr_pins) begin
                        st_r       <= ST_ACK;
                        sda_oe_r   <= 1'b1;
                        rnw_r      <= sh_r[0];
                        byte_idx_r <= 2'h0;
                        rd_half_r  <= 1'b0;
                        i2c_rd_r   <= sh_r[0];
                     end else begin
                        st_r <= ST_IDLE;
                     end
                  end
               end
               ST_WDATA: begin
                  if (bit_cnt_r == 4'h8) begin
                     st_r     <= ST_ACK;
                     sda_oe_r <= 1'b1;
                     if (byte_idx_r != 2'h3) begin
                        byte_idx_r <= byte_idx_r + 2'h1;
                     end
                     case (byte_idx_r)
                        2'h0: begin
                           ptr_r <= sh_r[1:0];
                        end
                        2'h1: begin
                           msb_r <= sh_r;
                           if (ptr_r == REG_CONFIG) begin
                              i2c_wr_r    <= 1'b1;
                              i2c_wdata_r <= {8'h00, sh_r};
                           end
                        end
                        2'h2: begin
                           if (ptr_r != REG_CONFIG) begin
                              i2c_wr_r    <= 1'b1;
                              i2c_wdata_r <= {msb_r, sh_r};
                           end
                        end
                        default: begin
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  bit_cnt_r <= 4'h0;
                  if (rnw_r) begin
                     tx_r      <= tx_byte;
                     sda_oe_r  <= ~tx_byte[7];
                     rd_half_r <= ~rd_half_r;
                     st_r      <= ST_RDATA;
                  end else begin
                     sda_oe_r <= 1'b0;
                     st_r     <= ST_WDATA;
                  end
               end
               ST_RDATA: begin
                  if (bit_cnt_r == 4'h7) begin
                     sda_oe_r <= 1'b0;
                     st_r     <= ST_RACK;
                  end else begin
                     tx_r      <= {tx_r[6:0], 1'b0};
                     sda_oe_r  <= ~tx_r[6];
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
               ST_RACK: begin
                  // A master that declines the byte ends the read.
                  if (nack_r) begin
                     st_r <= ST_IDLE;
                  end else begin
                     tx_r      <= tx_byte;
                     sda_oe_r  <= ~tx_byte[7];
                     rd_half_r <= ~rd_half_r;
                     bit_cnt_r <= 4'h0;
                     st_r      <= ST_RDATA;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Writable registers; the local port wins over a same-cycle serial write.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_r  <= CFG_RST;
         trip_r <= TRIP_RST;
         hyst_r <= HYST_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            REG_CONFIG: cfg_r  <= reg_wdata[7:0] & CFG_WR_MASK;
            REG_HYST:   hyst_r <= reg_wdata;
            REG_TRIP:   trip_r <= reg_wdata;
            default: begin
            end
         endcase
      end else if (i2c_wr_r) begin
         case (ptr_r)
            REG_CONFIG: cfg_r  <= i2c_wdata_r[7:0] & CFG_WR_MASK;
            REG_HYST:   hyst_r <= i2c_wdata_r;
            REG_TRIP:   trip_r <= i2c_wdata_r;
            default: begin
            end
         endcase
      end
   end

   // Local read data stands only in the cycle after the strobe.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 16'h0000;
      end else if (reg_rd) begin
         rdata_r <= reg_value(reg_addr, cfg_r, trip_r, hyst_r, temp_r);
      end else begin
         rdata_r <= 16'h0000;
      end
   end

   // R12 conversions stop in shutdown.
   // R18 shutdown bit decode.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         conv_cnt_r    <= '0;
         conv_done_r   <= 1'b0;
         conv_active_r <= 1'b0;
         temp_r        <= TEMP_RST;
      end else begin
         conv_done_r <= 1'b0;
         if (cfg_r[CFG_SHDN_BIT]) begin
            conv_cnt_r    <= '0;
            conv_active_r <= 1'b0;
         end else if (conv_cnt_r == CONV_CNT_W'(CONV_CYCLES - 1)) begin
            conv_cnt_r    <= '0;
            conv_active_r <= 1'b1;
            conv_done_r   <= 1'b1;
            temp_r        <= {temp_in, 7'h00};
         end else begin
            conv_cnt_r    <= conv_cnt_r + CONV_CNT_W'(1);
            conv_active_r <= 1'b1;
         end
      end
   end

   // R20 signed compare of result against limits.
   always_comb begin
      if (temp_of(temp_r) > temp_of(trip_r)) begin
         cls = CLS_HI;
      end else if (temp_of(temp_r) < temp_of(hyst_r)) begin
         cls = CLS_LO;
      end else begin
         cls = CLS_MID;
      end
   end

   // R14 result filter.
   tal_fault_filter u_filter (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .conv_done (conv_done_r),
      .cls       (cls),
      .fq_sel    (cfg_r[CFG_FQ_MSB:CFG_FQ_LSB]),
      .qual_hi_r (qual_hi),
      .qual_lo_r (qual_lo)
   );

   // Comparator level; no qualified result in shutdown freezes it.
   // R1 set above trip.
   // R2 clear below hysteresis.
   // R7 frozen in shutdown.
   // R19 hold between limits.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cmp_level_r <= 1'b0;
      end else if (qual_hi) begin
         cmp_level_r <= 1'b1;
      end else if (qual_lo) begin
         cmp_level_r <= 1'b0;
      end
   end

   assign any_read   = reg_rd | i2c_rd_r;
   assign shdn_entry = cfg_r[CFG_SHDN_BIT] & ~shdn_q_r;

   // Interrupt latch; a new event wins over a read in the same cycle.
   // R3 trip event, read clears.
   // R4 hysteresis event re-arms.
   // R5 no self clearing.
   // R6 shutdown entry releases.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         shdn_q_r        <= 1'b0;
         int_pend_r      <= 1'b0;
         int_expect_lo_r <= 1'b0;
      end else begin
         shdn_q_r <= cfg_r[CFG_SHDN_BIT];
         if (shdn_entry && cfg_r[CFG_INT_BIT]) begin
            int_pend_r <= 1'b0;
         end else if (qual_hi && !int_expect_lo_r) begin
            int_pend_r      <= 1'b1;
            int_expect_lo_r <= 1'b1;
         end else if (qual_lo && int_expect_lo_r) begin
            int_pend_r      <= 1'b1;
            int_expect_lo_r <= 1'b0;
         end else if (any_read) begin
            int_pend_r <= 1'b0;
         end
      end
   end

   // R16 style select.
   assign alarm_level = cfg_r[CFG_INT_BIT] ? int_pend_r : cmp_level_r;

   // The pin only sinks, so active high means releasing while active.
   // R8 polarity default low.
   // R9 open drain drive.
   // R17 polarity decode.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         alarm_oe_r <= 1'b0;
      end else begin
         alarm_oe_r <= cfg_r[CFG_POL_BIT] ? ~alarm_level : alarm_level;
      end
   end

   // Output pins come straight from flops, except sda_out and alarm_out, which are tied low.
   assign reg_rdata   = rdata_r;
   assign sda_oe      = sda_oe_r;
   assign sda_out     = 1'b0;
   assign alarm_out   = 1'b0;
   assign alarm_oe    = alarm_oe_r;
   assign conv_active = conv_active_r;
endmodule

//--- include/tal_pkg.sv
// Shared constants, types and helpers for the thermal alarm output block.
package tal_pkg;

   // Register indexes, selected by the two low pointer bits.
   localparam logic [1:0] REG_TEMP   = 2'h0;
   localparam logic [1:0] REG_CONFIG = 2'h1;
   localparam logic [1:0] REG_HYST   = 2'h2;
   localparam logic [1:0] REG_TRIP   = 2'h3;

   // Configuration field positions.
   localparam int CFG_SHDN_BIT = 0;
   localparam int CFG_INT_BIT  = 1;
   localparam int CFG_POL_BIT  = 2;
   localparam int CFG_FQ_LSB   = 3;
   localparam int CFG_FQ_MSB   = 4;
   localparam logic [7:0] CFG_WR_MASK = 8'h1F;

   // Reset values; temperatures are 9-bit signed half degrees in bits 15..7.
   localparam logic [7:0]  CFG_RST  = 8'h00;
   localparam logic [15:0] TRIP_RST = 16'h5000;
   localparam logic [15:0] HYST_RST = 16'h4B00;
   localparam logic [15:0] TEMP_RST = 16'h0000;
   localparam int TEMP_W   = 9;
   localparam int TEMP_LSB = 7;

   // Fixed upper slave address bits.
   localparam logic [3:0] ADDR_FIXED = 4'h9;

   // Fault queue depths.
   localparam logic [2:0] FQ_N0 = 3'h1;
   localparam logic [2:0] FQ_N1 = 3'h2;
   localparam logic [2:0] FQ_N2 = 3'h4;
   localparam logic [2:0] FQ_N3 = 3'h6;

   // Conversion timing.
   localparam int unsigned CONV_TIME_MS = 55;
   localparam int unsigned CLK_FREQ_HZ  = 100000000;
   localparam int unsigned CONV_CYCLES  = CONV_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int CONV_CNT_W = 23;

   // Qualitative result of one conversion.
   typedef enum logic [1:0] {CLS_MID, CLS_HI, CLS_LO} tal_cls_t;

   // Number of agreeing conversions needed for a queue setting.
   function automatic logic [2:0] fq_need(input logic [1:0] sel);
      case (sel)
         2'h0:    fq_need = FQ_N0;
         2'h1:    fq_need = FQ_N1;
         2'h2:    fq_need = FQ_N2;
         default: fq_need = FQ_N3;
      endcase
   endfunction

endpackage

//--- design/tal_sync.sv
// Two-flop synchroniser for asynchronous inputs.
module tal_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         ref_clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= RST;
         q      <= RST;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

//--- design/tal_fault_filter.sv
// Fault queue: qualifies a result only after enough agreeing conversions.
module tal_fault_filter (
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic             conv_done,
   input  wire tal_pkg::tal_cls_t cls,
   input  wire logic [1:0]       fq_sel,
   output logic                  qual_hi_r,
   output logic                  qual_lo_r
);
   import tal_pkg::*;

   tal_cls_t   last_r;
   logic [2:0] run_r;
   logic [2:0] run_nxt;

   // Saturate at the deepest queue so the run count never wraps.
   always_comb begin
      if (cls == last_r) begin
         run_nxt = (run_r >= FQ_N3) ? run_r : run_r + 3'h1;
      end else begin
         run_nxt = 3'h1;
      end
   end

   // R14 transient suppression.
   // R15 consecutive count check.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         last_r    <= CLS_MID;
         run_r     <= 3'h0;
         qual_hi_r <= 1'b0;
         qual_lo_r <= 1'b0;
      end else begin
         qual_hi_r <= 1'b0;
         qual_lo_r <= 1'b0;
         if (conv_done) begin
            last_r    <= cls;
            run_r     <= run_nxt;
            qual_hi_r <= (cls == CLS_HI) && (run_nxt >= fq_need(fq_sel));
            qual_lo_r <= (cls == CLS_LO) && (run_nxt >= fq_need(fq_sel));
         end
      end
   end
endmodule

//--- verif/tal_alarm_checker.sv
// Port-level assertion checker for the thermal alarm block.
module tal_alarm_checker (
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic [1:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        sda_out,
   input wire logic        conv_active,
   input wire logic        alarm_out,
   input wire logic        alarm_oe
);
   import tal_pkg::*;

   // One clock domain, so clock and reset are given once.
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read answer");
   sda_drive_a: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   alarm_drive_a: assert property (alarm_out == 1'b0)
      else $error("alarm pin driven high");
   cfg_upper_a: assert property ($past(reg_rd && reg_addr == REG_CONFIG) |-> reg_rdata[15:5] == 11'h000)
      else $error("config upper bits not zero");
   shdn_stop_a: assert property (reg_wr && reg_addr == REG_CONFIG && reg_wdata[0] |-> ##[1:2] !conv_active)
      else $error("conversions still running in shutdown");
   shdn_resume_a: assert property (reg_wr && reg_addr == REG_CONFIG && !reg_wdata[0] |-> ##[1:2] conv_active)
      else $error("conversions not resumed");
   int_shdn_a: assert property (reg_wr && reg_addr == REG_CONFIG && reg_wdata[2:0] == 3'h3 |-> ##[1:3] !alarm_oe)
      else $error("interrupt alarm kept on shutdown entry");
   trip_back_a: assert property (reg_wr && reg_addr == REG_TRIP ##1 reg_rd && reg_addr == REG_TRIP |=> reg_rdata == $past(reg_wdata, 2))
      else $error("trip read back differs");
   hyst_back_a: assert property (reg_wr && reg_addr == REG_HYST ##1 reg_rd && reg_addr == REG_HYST |=> reg_rdata == $past(reg_wdata, 2))
      else $error("hysteresis read back differs");

   // Main scenarios reached.
   cover property (reg_wr && reg_addr == REG_CONFIG && reg_wdata[0]);
   cover property ($rose(alarm_oe));
   cover property ($fell(conv_active));
endmodule

bind tal_alarm_top tal_alarm_checker u_chk (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .sda_out, .conv_active, .alarm_out, .alarm_oe);

//--- verif/tal_host_model.sv
// Two-wire host master model driving the link clock and the data line.
module tal_host_model (
   input  wire logic ref_clk,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pull_r;

   // Data line has a pull-up, so a released line reads high.
   assign sda = !(pull_r || sda_oe);

   // Idle bus: both lines high, clock stands still between frames.
   initial begin
      scl = 1'b1;
      pull_r = 1'b0;
   end

   // A quarter of the 160 ns link clock period.
   task automatic q();
      repeat (4) @(posedge ref_clk);
   endtask

   // Data changes only while the clock is low and is sampled mid-high.
   task automatic bit_x(input logic b, output logic r);
      scl <= 1'b0;
      q();
      pull_r <= !b;
      q();
      scl <= 1'b1;
      q();
      r = sda;
      q();
   endtask

   // Start: data falls while the clock is high.
   task automatic start();
      pull_r <= 1'b1;
      q();
   endtask

   // address first
   // Eight bits most significant first, then the acknowledge slot.
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         bit_x(tx[i], rx[i]);
      end
   endtask

   // Stop: data rises while the clock is high, then the bus rests.
   task automatic stop();
      scl <= 1'b0;
      q();
      pull_r <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      pull_r <= 1'b0;
      q();
      q();
   endtask
endmodule

//--- verif/tal_alarm_top_bench.sv
// Self-checking bench for the thermal alarm block.
module tal_alarm_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import tal_pkg::*;

   localparam int CONV = 50;
   localparam logic [8:0] HOT = 9'h0A1;
   localparam logic [8:0] MID = 9'h0A0;
   localparam logic [8:0] COLD = 9'h000;
   localparam logic [9:0] CT [5] = '{10'h143, 10'h141, 10'h12D, 10'h12A, 10'h140};
   localparam int NQ [4] = '{1, 2, 4, 6};

   logic        ref_clk, rstn, reg_wr, reg_rd, scl, sda, sda_oe, sda_out;
   logic        conv_active, alarm_out, alarm_oe, pol, ack;
   logic [1:0]  reg_addr;
   logic [2:0]  strap;
   logic [8:0]  temp_in;
   logic [15:0] reg_wdata, reg_rdata, rd;
   int          num_errors, samples_checked;

   tal_alarm_top #(.CONV_CYCLES(CONV)) dut (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
      .addr_select_hi(strap[2]), .addr_select_mid(strap[1]), .addr_select_lo(strap[0]),
      .temp_in, .conv_active, .alarm_out, .alarm_oe);

   tal_host_model host (.ref_clk, .sda_oe, .scl, .sda);

   // 100 MHz block clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Local port: one-cycle strobes, read answer in the following cycle only.
   task automatic lw(input logic [1:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      cyc(1);
      reg_wr <= 1'b0;
   endtask

   task automatic lr(input logic [1:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc(1);
      reg_rd <= 1'b0;
      cyc(1);
      check(reg_rdata, e);
   endtask

   // Pin is pulled low when active with low polarity, or inactive with high.
   task automatic al(input logic act);
      cyc(8);
      check(16'(alarm_oe), 16'(act ^ pol));
   endtask

   task automatic step(input logic [8:0] t, input logic act);
      temp_in <= t;
      cyc(CONV);
      al(act);
   endtask

   // One link frame; a read frame ends with a master refusal on its last byte.
   task automatic frame(input logic [7:0] ad, input logic [23:0] wd, input int nb);
      logic [8:0] r;
      host.start();
      host.xfer({ad, 1'b1}, r);
      ack = !r[0];
      rd = 16'h0000;
      for (int i = 0; i < nb; i++) begin
         if (ad[0]) begin
            host.xfer({8'hFF, i == nb - 1}, r);
            rd = {rd[7:0], r[8:1]};
         end else begin
            host.xfer({wd[23 - 8 * i -: 8], 1'b1}, r);
         end
      end
      host.stop();
   endtask

   // A hang counts as a mismatch.
   initial begin
      cyc(60000);
      num_errors++;
      end_sim();
   end

   initial begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 2'h0;
      reg_wdata = 16'h0000;
      strap = 3'h5;
      temp_in = COLD;
      pol = 1'b0;
      num_errors = 0;
      samples_checked = 0;
      cyc(16);
      rstn <= 1'b1;
      cyc(2);
      lr(REG_CONFIG, {8'h00, CFG_RST});
      lr(REG_TRIP, TRIP_RST);
      al(1'b0);
      check(16'(conv_active), 16'h0001);
      foreach (CT[i]) step(CT[i][9:1], CT[i][0]);
      lr(REG_TEMP, {MID, 7'h00});
      lw(REG_TEMP, 16'h1234);
      lr(REG_TEMP, {MID, 7'h00});
      lw(REG_TRIP, 16'hFF00);
      lr(REG_TRIP, 16'hFF00);
      lw(REG_HYST, 16'hFE00);
      lr(REG_HYST, 16'hFE00);
      step(9'h1FF, 1'b1);
      step(9'h1FB, 1'b0);
      lw(REG_TRIP, TRIP_RST);
      lr(REG_TRIP, TRIP_RST);
      lw(REG_HYST, HYST_RST);
      lr(REG_HYST, HYST_RST);
      lw(REG_CONFIG, 16'h0004);
      pol = 1'b1;
      al(1'b0);
      step(HOT, 1'b1);
      lw(REG_CONFIG, 16'h0000);
      pol = 1'b0;
      al(1'b1);
      // Each queue depth: full run accepted; for depths above one, a shorter excursion is ignored.
      for (int f = 0; f < 4; f++) begin
         lw(REG_CONFIG, 16'(f << 3));
         temp_in <= COLD;
         cyc(6 * CONV);
         al(1'b0);
         temp_in <= HOT;
         if (NQ[f] > 1) begin
            cyc((NQ[f] - 1) * CONV - 12);
            al(1'b0);
         end
         cyc(CONV);
         al(1'b1);
      end
      // Fresh reset so the interrupt sequence starts clean.
      rstn <= 1'b0;
      cyc(4);
      rstn <= 1'b1;
      cyc(2);
      lw(REG_CONFIG, 16'h0002);
      step(HOT, 1'b1);
      lr(REG_TEMP, {HOT, 7'h00});
      al(1'b0);
      step(HOT, 1'b0);
      step(MID, 1'b0);
      step(COLD, 1'b1);
      step(MID, 1'b1);
      lr(REG_CONFIG, 16'h0002);
      al(1'b0);
      step(HOT, 1'b1);
      frame(8'h9B, 24'h0, 2);
      al(1'b0);
      step(COLD, 1'b1);
      lw(REG_CONFIG, 16'h0003);
      al(1'b0);
      check(16'(conv_active), 16'h0000);
      temp_in <= HOT;
      cyc(2 * CONV);
      lr(REG_TEMP, {COLD, 7'h00});
      lw(REG_TRIP, 16'h5A00);
      lr(REG_TRIP, 16'h5A00);
      frame(8'h9A, {8'h03, TRIP_RST}, 3);
      check(16'(ack), 16'h0001);
      lr(REG_TRIP, TRIP_RST);
      lw(REG_CONFIG, 16'h0000);
      step(HOT, 1'b1);
      lw(REG_CONFIG, 16'h00E1);
      lr(REG_CONFIG, 16'h0001);
      temp_in <= COLD;
      cyc(2 * CONV);
      al(1'b1);
      lw(REG_CONFIG, 16'h0000);
      step(COLD, 1'b0);
      // Every strap setting: own address answered, neighbours ignored.
      for (int s = 0; s < 8; s++) begin
         strap <= 3'(s);
         cyc(4);
         frame({4'h9, 3'(s), 1'b0}, 24'h0, 0);
         check(16'(ack), 16'h0001);
         frame({4'h9, 3'(s) ^ 3'h1, 1'b0}, 24'h0, 0);
         check(16'(ack), 16'h0000);
         frame({4'hA, 3'(s), 1'b0}, 24'h0, 0);
         check(16'(ack), 16'h0000);
      end
      strap <= 3'h5;
      cyc(4);
      frame(8'h9A, 24'h035A00, 3);
      lr(REG_TRIP, 16'h5A00);
      frame(8'h9A, 24'h030000, 1);
      frame(8'h9B, 24'h0, 2);
      check(rd, 16'h5A00);
      end_sim();
   end
endmodule
